// File: ccd_charge_injection_self_test.sv
// Charge injection self-test controller of the line sensor with its test registers and frame sequencer.
//
// Operation
// - Injection runs acquire, flush, shift, then frame-ready.
// - Test controller drives injection during integration.
// - Unlock stays open until the next reset.
// - Pattern bits choose pixel groups; low bits 0x1.
// - Analog test pins are outputs unless injecting.
`timescale 1ns/1ps
`include "ccd_selftest_map.svh"

module ccd_charge_injection_self_test (
    input wire logic clk,
    input wire logic rstn,
    input wire logic test_enable,
    input wire logic center_region_select,
    input wire logic readout_direction,
    input wire logic acquire_gate,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] analog_test_pins_in,
    output logic [1:0] analog_test_pins_out,
    output logic [1:0] analog_test_pins_oe,
    output logic test_unlocked,
    output logic injection_mode,
    output logic inject_enable,
    output logic frame_ready,
    output logic shift_valid,
    output logic [9:0] shift_pixel,
    output logic shift_charge,
    output logic shift_center,
    output logic shift_reverse
);

    // ************************************************************************
    // Pin synchronisers
    // ************************************************************************
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic test_enable_s;
    logic gate_s;
    logic gate_prev;
    logic [1:0] ana_s;

    // Every pin passes two flops; only the second stage is read.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= {analog_test_pins_in, readout_direction, center_region_select, acquire_gate, test_enable};
            pin_sync <= pin_meta;
        end
    end

    assign test_enable_s = pin_sync[0];
    assign gate_s = pin_sync[1];
    assign ana_s = pin_sync[5:4];

    // Edge detection works on the synchronised gate only.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gate_prev <= 1'b0;
        end else begin
            gate_prev <= gate_s;
        end
    end

    // ************************************************************************
    // Test registers and unlock sequence
    // ************************************************************************
    ccd_selftest_pkg::unlock_state_type unlock_state;
    logic [7:0] key_a;
    logic [7:0] key_b;
    logic [7:0] control_a;
    logic [7:0] pattern;
    logic [7:0] control_b;
    logic [7:0] control_c;
    logic step_ok;
    logic cfg_wr_ok;

    // A write matches the next expected step of the unlock sequence.
    always_comb begin
        step_ok = 1'b0;
        case (unlock_state)
            ccd_selftest_pkg::UNL_KEY_A: step_ok = (reg_addr == `ADDR_TEST_UNLOCK_KEY_A) && (reg_wdata == `KEY_A_VALUE);
            ccd_selftest_pkg::UNL_KEY_B: step_ok = (reg_addr == `ADDR_TEST_UNLOCK_KEY_B) && (reg_wdata == `KEY_B_VALUE);
            ccd_selftest_pkg::UNL_CTRL_A: step_ok = (reg_addr == `ADDR_TEST_CONTROL_A) && (reg_wdata == `CONTROL_A_TEST);
            ccd_selftest_pkg::UNL_CTRL_B: step_ok = (reg_addr == `ADDR_TEST_CONTROL_B) && (reg_wdata == `CONTROL_B_TEST);
            ccd_selftest_pkg::UNL_CTRL_C: step_ok = (reg_addr == `ADDR_TEST_CONTROL_C) && (reg_wdata == `CONTROL_C_TEST);
            ccd_selftest_pkg::UNL_OPEN: step_ok = 1'b0;
            default: step_ok = 1'b0;
        endcase
    end

    // Sequence tracker: a wrong write restarts it at step one, even a
    // correct first key write. Once open it stays open until reset, so a
    // stray write during the test can never lock the host out mid-frame.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            unlock_state <= ccd_selftest_pkg::UNL_KEY_A;
        end else if (reg_wr && unlock_state != ccd_selftest_pkg::UNL_OPEN) begin
            case (unlock_state)
                ccd_selftest_pkg::UNL_KEY_A: begin
                    if (step_ok) unlock_state <= ccd_selftest_pkg::UNL_KEY_B;
                end
                ccd_selftest_pkg::UNL_KEY_B: begin
                    unlock_state <= step_ok ? ccd_selftest_pkg::UNL_CTRL_A : ccd_selftest_pkg::UNL_KEY_A;
                end
                ccd_selftest_pkg::UNL_CTRL_A: begin
                    unlock_state <= step_ok ? ccd_selftest_pkg::UNL_CTRL_B : ccd_selftest_pkg::UNL_KEY_A;
                end
                ccd_selftest_pkg::UNL_CTRL_B: begin
                    unlock_state <= step_ok ? ccd_selftest_pkg::UNL_CTRL_C : ccd_selftest_pkg::UNL_KEY_A;
                end
                ccd_selftest_pkg::UNL_CTRL_C: begin
                    unlock_state <= step_ok ? ccd_selftest_pkg::UNL_OPEN : ccd_selftest_pkg::UNL_KEY_A;
                end
                default: unlock_state <= ccd_selftest_pkg::UNL_KEY_A;
            endcase
        end
    end

    // Control registers take a write when open, or when it is the expected
    // unlock step; the pattern register only once open.
    assign cfg_wr_ok = (unlock_state == ccd_selftest_pkg::UNL_OPEN) || step_ok;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            key_a <= `RESET_KEY;
            key_b <= `RESET_KEY;
            control_a <= `RESET_CONTROL_A;
            pattern <= `RESET_PATTERN;
            control_b <= `RESET_CONTROL_B;
            control_c <= `RESET_CONTROL_C;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_TEST_UNLOCK_KEY_A: key_a <= reg_wdata;
                `ADDR_TEST_UNLOCK_KEY_B: key_b <= reg_wdata;
                `ADDR_TEST_CONTROL_A: if (cfg_wr_ok) control_a <= reg_wdata;
                `ADDR_INJECTION_PATTERN_SELECT: if (unlock_state == ccd_selftest_pkg::UNL_OPEN) pattern <= reg_wdata;
                `ADDR_TEST_CONTROL_B: if (cfg_wr_ok) control_b <= reg_wdata;
                `ADDR_TEST_CONTROL_C: if (cfg_wr_ok) control_c <= reg_wdata;
                default: key_a <= key_a;
            endcase
        end
    end

    // Read data is registered; unmapped offsets read as zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_TEST_UNLOCK_KEY_A: reg_rdata <= key_a;
                `ADDR_TEST_UNLOCK_KEY_B: reg_rdata <= key_b;
                `ADDR_TEST_CONTROL_A: reg_rdata <= control_a;
                `ADDR_INJECTION_PATTERN_SELECT: reg_rdata <= pattern;
                `ADDR_TEST_CONTROL_B: reg_rdata <= control_b;
                `ADDR_TEST_CONTROL_C: reg_rdata <= control_c;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    assign test_unlocked = (unlock_state == ccd_selftest_pkg::UNL_OPEN);

    // ************************************************************************
    // Injection mode and analog pin direction
    // ************************************************************************
    // Injection needs the open unlock, the test pin high and the test
    // control values in place; restoring any of them ends it one cycle after the change is seen.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            injection_mode <= 1'b0;
        end else begin
            injection_mode <= test_unlocked && test_enable_s && (control_a == `CONTROL_A_TEST)
                && (control_b == `CONTROL_B_TEST) && (control_c == `CONTROL_C_TEST);
        end
    end

    // The pins drive low as outputs by default and release only in injection mode.
    assign analog_test_pins_oe = injection_mode ? 2'h0 : 2'h3;
    assign analog_test_pins_out = 2'h0;

    // ************************************************************************
    // Acquisition sequencer
    // ************************************************************************
    ccd_selftest_pkg::seq_state_type seq_state;
    logic [7:0] flush_count;
    logic [9:0] pixel;
    logic [7:0] frame_pattern;
    logic frame_injected;
    logic pixel_selected;

    injection_pattern_decode u_decode (
        .pattern(frame_pattern),
        .pixel(pixel),
        .selected(pixel_selected)
    );

    // Same flow with or without injection: gate high integrates, gate low
    // flushes, then the frame shifts and frame-ready rises until the next gate.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seq_state <= ccd_selftest_pkg::SEQ_IDLE;
            flush_count <= 8'h00;
            pixel <= 10'h000;
        end else begin
            case (seq_state)
                ccd_selftest_pkg::SEQ_IDLE, ccd_selftest_pkg::SEQ_READY: begin
                    if (gate_s && !gate_prev) seq_state <= ccd_selftest_pkg::SEQ_INTEGRATE;
                end
                ccd_selftest_pkg::SEQ_INTEGRATE: begin
                    if (!gate_s) begin
                        seq_state <= ccd_selftest_pkg::SEQ_FLUSH;
                        flush_count <= 8'(`FLUSH_CYCLES - 1);
                    end
                end
                ccd_selftest_pkg::SEQ_FLUSH: begin
                    if (flush_count == 8'h00) begin
                        seq_state <= ccd_selftest_pkg::SEQ_SHIFT;
                        pixel <= 10'h000;
                    end else begin
                        flush_count <= flush_count - 8'h01;
                    end
                end
                ccd_selftest_pkg::SEQ_SHIFT: begin
                    pixel <= pixel + 10'h001;
                    if (pixel == `PIXEL_LAST) seq_state <= ccd_selftest_pkg::SEQ_READY;
                end
                default: seq_state <= ccd_selftest_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Pattern and mode are frozen at the gate edge so a register write
    // during the frame cannot tear the stimulus.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_pattern <= `RESET_PATTERN;
            frame_injected <= 1'b0;
        end else if (gate_s && !gate_prev && (seq_state == ccd_selftest_pkg::SEQ_IDLE
            || seq_state == ccd_selftest_pkg::SEQ_READY)) begin
            frame_pattern <= pattern;
            frame_injected <= injection_mode && ana_s[0];
        end
    end

    assign frame_ready = (seq_state == ccd_selftest_pkg::SEQ_READY);
    assign inject_enable = (seq_state == ccd_selftest_pkg::SEQ_INTEGRATE) && frame_injected;

    // Shifted pixel data comes from flops, one pixel per cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_valid <= 1'b0;
            shift_pixel <= 10'h000;
            shift_charge <= 1'b0;
            shift_center <= 1'b0;
            shift_reverse <= 1'b0;
        end else begin
            shift_valid <= (seq_state == ccd_selftest_pkg::SEQ_SHIFT);
            shift_pixel <= pixel;
            shift_charge <= (seq_state == ccd_selftest_pkg::SEQ_SHIFT) && frame_injected && pixel_selected;
            shift_center <= pin_sync[2];
            shift_reverse <= pin_sync[3];
        end
    end

    // ************************************************************************
    // Checks
    // ************************************************************************
    logic [7:0] flush_seen;

    // Counts the cycles of the current flush, so the length check needs no long repetition.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flush_seen <= 8'h00;
        end else if (seq_state == ccd_selftest_pkg::SEQ_FLUSH) begin
            flush_seen <= flush_seen + 8'h01;
        end else begin
            flush_seen <= 8'h00;
        end
    end

    unlock_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
        test_unlocked |=> test_unlocked) else $error("Unlock dropped before reset.");
    unlock_order_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(test_unlocked) |-> $past(reg_wr) && $past(reg_addr) == `ADDR_TEST_CONTROL_C
        && control_c == `CONTROL_C_TEST) else $error("Unlock without final key write.");
    pin_dir_a: assert property (@(posedge clk) disable iff (!rstn)
        !injection_mode |-> analog_test_pins_oe == 2'h3) else $error("Analog pins released outside test.");
    inject_mode_a: assert property (@(posedge clk) disable iff (!rstn)
        injection_mode |-> $past(test_enable_s) && test_unlocked) else $error("Injection without enable.");
    inject_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        inject_enable |-> gate_prev ##1 1'b1) else $error("Injection outside integration.");
    flush_len_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(seq_state == ccd_selftest_pkg::SEQ_SHIFT) |-> flush_seen == 8'(`FLUSH_CYCLES))
        else $error("Flush length wrong.");
    ready_after_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(frame_ready) |-> $past(pixel) == `PIXEL_LAST && shift_valid && shift_pixel == `PIXEL_LAST
        ##1 !shift_valid) else $error("Frame ready before shift end.");
    charge_sel_a: assert property (@(posedge clk) disable iff (!rstn)
        shift_charge |-> frame_injected && frame_pattern[`PAT_LOW_MSB:0] == `PAT_LOW_VALUE)
        else $error("Charge with bad pattern.");
    odd_only_a: assert property (@(posedge clk) disable iff (!rstn)
        shift_charge && frame_pattern[6:3] == 4'h8 |-> shift_pixel[0]) else $error("Even pixel charged.");

    unlock_c: cover property (@(posedge clk) disable iff (!rstn) $rose(test_unlocked));
    inject_c: cover property (@(posedge clk) disable iff (!rstn) $rose(inject_enable));
    charge_c: cover property (@(posedge clk) disable iff (!rstn) shift_charge);
    ready_c: cover property (@(posedge clk) disable iff (!rstn) $rose(frame_ready) && frame_injected);

endmodule : ccd_charge_injection_self_test

// File: ccd_selftest_map.svh
// Register offsets, key values, field positions and timing counts of the charge injection self-test.
`ifndef CCD_SELFTEST_MAP_SVH
`define CCD_SELFTEST_MAP_SVH

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define ADDR_TEST_UNLOCK_KEY_A 8'hD0
`define ADDR_TEST_UNLOCK_KEY_B 8'hD1
`define ADDR_TEST_CONTROL_A 8'hD2
`define ADDR_INJECTION_PATTERN_SELECT 8'hD3
`define ADDR_TEST_CONTROL_B 8'hD4
`define ADDR_TEST_CONTROL_C 8'hD5

// ****************************************************************************
// Unlock sequence values and reset values
// ****************************************************************************
`define KEY_A_VALUE 8'h4A
`define KEY_B_VALUE 8'h66
`define CONTROL_A_TEST 8'h02
`define CONTROL_B_TEST 8'h20
`define CONTROL_C_TEST 8'h21
`define RESET_KEY 8'h00
`define RESET_CONTROL_A 8'h00
`define RESET_PATTERN 8'h00
`define RESET_CONTROL_B 8'h00
`define RESET_CONTROL_C 8'h01

// ****************************************************************************
// Pattern register fields
// ****************************************************************************
`define PAT_ODD_BIT 6
`define PAT_MOD4_2_BIT 5
`define PAT_MOD8_4_BIT 4
`define PAT_MOD8_0_BIT 3
`define PAT_LOW_MSB 2
`define PAT_LOW_VALUE 3'h1

// ****************************************************************************
// Array size and sequencer timing
// ****************************************************************************
`define PIXEL_COUNT 11'h400
`define PIXEL_LAST 10'h3FF
`define FLUSH_TIME_NS 100
`define CLK_PERIOD_NS 5
`define FLUSH_CYCLES ((`FLUSH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: ccd_selftest_pkg.sv
// Types shared by the charge injection self-test files.
package ccd_selftest_pkg;

    // One-hot acquisition sequencer states.
    typedef enum logic [4:0] {
        SEQ_IDLE = 5'b00001,
        SEQ_INTEGRATE = 5'b00010,
        SEQ_FLUSH = 5'b00100,
        SEQ_SHIFT = 5'b01000,
        SEQ_READY = 5'b10000
    } seq_state_type;

    // One-hot position in the unlock write sequence.
    typedef enum logic [5:0] {
        UNL_KEY_A = 6'b000001,
        UNL_KEY_B = 6'b000010,
        UNL_CTRL_A = 6'b000100,
        UNL_CTRL_B = 6'b001000,
        UNL_CTRL_C = 6'b010000,
        UNL_OPEN = 6'b100000
    } unlock_state_type;

endpackage : ccd_selftest_pkg

// File: injection_pattern_decode.sv
// Decodes the injection pattern register into a per-pixel charge selection.
`timescale 1ns/1ps
`include "ccd_selftest_map.svh"

module injection_pattern_decode (
    input wire logic [7:0] pattern,
    input wire logic [9:0] pixel,
    output logic selected
);

    // ************************************************************************
    // Pixel selection
    // ************************************************************************
    // Each set bit adds its pixel group; bit 7 is ignored and a wrong low
    // field selects no pixel at all rather than guessing.
    always_comb begin
        selected = 1'b0;
        if (pattern[`PAT_LOW_MSB:0] == `PAT_LOW_VALUE) begin
            selected = (pattern[`PAT_ODD_BIT] && pixel[0])
                || (pattern[`PAT_MOD4_2_BIT] && (pixel[1:0] == 2'h2))
                || (pattern[`PAT_MOD8_4_BIT] && (pixel[2:0] == 3'h4))
                || (pattern[`PAT_MOD8_0_BIT] && (pixel[2:0] == 3'h0));
        end
    end

endmodule : injection_pattern_decode

// File: host_model.sv
// Host controller model that drives the self-test pins and the register port.
`timescale 1ns/1ps
`include "ccd_selftest_map.svh"

// ****************************************************************************
// Host controller
// ****************************************************************************
module host_model (
    input wire logic clk,
    input wire logic mode_on,
    input wire logic [7:0] rdata,
    output logic test_en,
    output logic center,
    output logic dir,
    output logic gate,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic [1:0] ana_lvl,
    output logic ana_drv
);
    // All lines idle at time zero; the analog pins are not driven by the host.
    initial begin
        {test_en, center, dir, gate, wr, rd, ana_drv} = 7'h00;
        {addr, wdata} = 16'h0000;
        ana_lvl = 2'h0;
    end

    // One write; strobe and qualifiers move only just after an edge.
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {wr, addr, wdata} = {1'b1, a, d};
        @(posedge clk) #1;
        wr = 1'b0;
    endtask : wr_reg

    // One read; the data is taken at the edge that ends the strobe.
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        {rd, addr} = {1'b1, a};
        @(posedge clk) #1;
        rd = 1'b0;
        d = rdata;
    endtask : rd_reg

    // Differential readout is a board setting with no pin on this block.
    task enter(input logic c, input logic r);
        {test_en, center, dir} = {1'b1, c, r};
    endtask : enter

    // The keys go out in the fixed order, nothing else between them.
    task unlock();
        wr_reg(`ADDR_TEST_UNLOCK_KEY_A, 8'h4A);
        wr_reg(`ADDR_TEST_UNLOCK_KEY_B, 8'h66);
        wr_reg(`ADDR_TEST_CONTROL_A, 8'h02);
        wr_reg(`ADDR_TEST_CONTROL_B, 8'h20);
        wr_reg(`ADDR_TEST_CONTROL_C, 8'h21);
    endtask : unlock

    // Driving against the device's own pad driver would damage it, so wait for the mode first.
    task apply();
        for (int i = 0; i < 20 && mode_on !== 1'b1; i++) @(posedge clk) #1;
        ana_lvl = 2'h1;
        ana_drv = mode_on;
    endtask : apply

    // The host lets go of the analog pins.
    task release_v();
        ana_drv = 1'b0;
    endtask : release_v

    // Settle for 10 us, then one gate of exactly 20 us at 5 ns a cycle.
    task acquire();
        repeat (2000) @(posedge clk);
        #1;
        gate = 1'b1;
        repeat (4000) @(posedge clk);
        #1;
        gate = 1'b0;
    endtask : acquire

    // Control and pattern registers go back to their initial values in the fixed order.
    task restore();
        wr_reg(`ADDR_TEST_CONTROL_B, 8'h00);
        wr_reg(`ADDR_TEST_CONTROL_C, 8'h01);
        wr_reg(`ADDR_TEST_CONTROL_A, 8'h00);
        wr_reg(`ADDR_INJECTION_PATTERN_SELECT, 8'h00);
    endtask : restore

    // Test enable drops first, then the application pin levels return.
    task leave();
        test_en = 1'b0;
        {center, dir} = 2'h0;
    endtask : leave
endmodule : host_model

// File: tb.sv
// Self-checking bench for the charge injection self-test block.
`timescale 1ns/1ps
`include "ccd_selftest_map.svh"

// ****************************************************************************
// Bench top
// ****************************************************************************
module tb;
    logic clk, rstn, test_en, center, dir, gate, wr, rd, ana_drv, flt;
    logic [7:0] addr, wdata, rdata, rv;
    logic [1:0] ana_lvl, ana_in, ana_out, ana_oe;
    logic unlocked, mode_on, inj_en, ready, sv, sc, s_ctr, s_rev;
    logic [9:0] spix;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    localparam logic [7:0] RA [5] = '{8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'h10};
    localparam logic [7:0] RE [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

    // Pad level: device driver first, then host, else a value that flips each cycle.
    assign ana_in = (ana_oe & ana_out) | (~ana_oe & (ana_drv ? ana_lvl : {flt, ~flt}));

    ccd_charge_injection_self_test dut_u (
        .clk(clk), .rstn(rstn), .test_enable(test_en), .center_region_select(center),
        .readout_direction(dir), .acquire_gate(gate), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .analog_test_pins_in(ana_in),
        .analog_test_pins_out(ana_out), .analog_test_pins_oe(ana_oe), .test_unlocked(unlocked),
        .injection_mode(mode_on), .inject_enable(inj_en), .frame_ready(ready), .shift_valid(sv),
        .shift_pixel(spix), .shift_charge(sc), .shift_center(s_ctr), .shift_reverse(s_rev));
    host_model host_u (
        .clk(clk), .mode_on(mode_on), .rdata(rdata), .test_en(test_en), .center(center), .dir(dir),
        .gate(gate), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .ana_lvl(ana_lvl), .ana_drv(ana_drv));

    // A 200 MHz clock and the floating pad pattern.
    initial begin
        clk = 1'b0;
        flt = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) flt <= ~flt;

    // Three frames take about 21250 cycles, so the ceiling leaves ample margin.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            $display("[ERR] %0t run timed out", $time);
            end_sim();
        end
    end

    task chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task chk_idx(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t pixel got %0d expected %0d", $time, got, exp);
        end
    endtask : chk_idx

    // Charge a pixel should carry; wrong low bits give none at all.
    function automatic logic exp_charge(input logic [7:0] p, input logic [9:0] x);
        logic hit;
        hit = (p[6] & x[0]) | (p[5] & (x[1:0] == 2'h2));
        hit = hit | (p[4] & (x[2:0] == 3'h4)) | (p[3] & (x[2:0] == 3'h0));
        return hit & (p[2:0] == 3'h1);
    endfunction : exp_charge

    task do_reset();
        rstn = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
    endtask : do_reset

    // Control, pattern and an unmapped address read back their initial values.
    task chk_defaults();
        for (int i = 0; i < 5; i++) begin
            host_u.rd_reg(RA[i], rv);
            chk_byte(rv, RE[i]);
        end
    endtask : chk_defaults

    task t_reset();
        chk_byte({6'h00, ana_oe}, 8'h03);
        chk_byte({6'h00, ana_out}, 8'h00);
        chk_bit(unlocked, 1'b0);
        chk_bit(ready, 1'b0);
        chk_defaults();
    endtask : t_reset

    // A locked pattern write and an out-of-order key leave everything closed.
    task t_locked();
        host_u.wr_reg(`ADDR_INJECTION_PATTERN_SELECT, 8'h49);
        host_u.wr_reg(`ADDR_TEST_UNLOCK_KEY_A, 8'h4A);
        host_u.wr_reg(`ADDR_TEST_UNLOCK_KEY_B, 8'h66);
        host_u.wr_reg(`ADDR_TEST_CONTROL_B, 8'h20);
        host_u.wr_reg(`ADDR_TEST_CONTROL_A, 8'h02);
        host_u.wr_reg(`ADDR_TEST_CONTROL_C, 8'h21);
        chk_bit(unlocked, 1'b0);
        chk_defaults();
    endtask : t_locked

    task t_unlock();
        host_u.unlock();
        @(posedge clk) #1;
        chk_bit(unlocked, 1'b1);
        chk_bit(mode_on, 1'b0);
        host_u.enter(1'b1, 1'b0);
        repeat (5) @(posedge clk);
        #1;
        chk_bit(mode_on, 1'b1);
        chk_byte({6'h00, ana_oe}, 8'h00);
    endtask : t_unlock

    // One injected frame: integration, then every pixel in order, then frame ready.
    task t_frame(input logic [7:0] p);
        host_u.wr_reg(`ADDR_INJECTION_PATTERN_SELECT, p);
        host_u.rd_reg(`ADDR_INJECTION_PATTERN_SELECT, rv);
        chk_byte(rv, p);
        host_u.apply();
        fork
            host_u.acquire();
            begin
                repeat (2100) @(posedge clk);
                #1;
                chk_bit(inj_en, 1'b1);
                chk_bit(ready, 1'b0);
            end
        join
        for (int k = 0; k < 200 && sv !== 1'b1; k++) @(posedge clk) #1;
        chk_bit(s_ctr, 1'b1);
        chk_bit(s_rev, 1'b0);
        for (int i = 0; i < 1024; i++) begin
            chk_bit(sv, 1'b1);
            chk_idx(spix, 10'(i));
            chk_bit(sc, exp_charge(p, 10'(i)));
            @(posedge clk) #1;
        end
        for (int k = 0; k < 8 && ready !== 1'b1; k++) @(posedge clk) #1;
        chk_bit(ready, 1'b1);
    endtask : t_frame

    // Restoring drops the mode but not the unlock; only a reset closes it.
    task t_exit();
        host_u.release_v();
        host_u.restore();
        repeat (3) @(posedge clk);
        #1;
        chk_bit(mode_on, 1'b0);
        chk_byte({6'h00, ana_oe}, 8'h03);
        chk_bit(unlocked, 1'b1);
        chk_defaults();
        host_u.leave();
        do_reset();
        chk_bit(unlocked, 1'b0);
    endtask : t_exit

    task end_sim();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Main sequence; the last pattern has wrong low bits and sets unused bit 7 in the second.
    initial begin
        do_reset();
        t_reset();
        t_locked();
        t_unlock();
        t_frame(8'h41);
        t_frame(8'hB9);
        t_frame(8'h7A);
        t_exit();
        end_sim();
    end
endmodule : tb
